/* File: inc/bcdu_cfg.svh */
`ifndef BCDU_CFG_SVH
`define BCDU_CFG_SVH
// ==========================================
// Opcodes and field layout
`define BCDU_OP_ADJ_WORD    16'h0007
`define BCDU_OP_DEC_MASK    16'hFC00
`define BCDU_OP_DEC_MATCH   16'h0400
`define BCDU_DEST_BIT       9
`define BCDU_BANK_BIT       8
`define BCDU_ADDR_MSB       7
// ==========================================
// Arithmetic constants
`define BCDU_BCD_MAX        4'h9
`define BCDU_BCD_FIX        4'h6
`define BCDU_DEC_STEP       8'h01
`define BCDU_DEC_NIB        4'h1
`define BCDU_DEC_OVF        8'h80
// ==========================================
// Access bank split: low addresses to bank 0, the rest to the top bank
`define BCDU_ACC_SPLIT      8'h80
`define BCDU_ACC_HI_BANK    4'hF
// ==========================================
// Register bus map
`define BCDU_REG_INSTR      12'h000
`define BCDU_REG_ACC        12'h004
`define BCDU_REG_STATUS     12'h008
`define BCDU_REG_BANK       12'h00C
`define BCDU_MEM_BASE       12'h800
`define BCDU_ST_C           0
`define BCDU_ST_DIGIT       1
`define BCDU_ST_Z           2
`define BCDU_ST_OVF         3
`define BCDU_ST_N           4
`define BCDU_ST_BUSY        8
`endif

/* File: inc/bcdu_pkg.sv */
package bcdu_pkg;
   typedef enum logic [2:0]
   {
      BCDU_IDLE  = 3'b000,
      BCDU_DECOD = 3'b001,
      BCDU_READ  = 3'b011,
      BCDU_PROC  = 3'b010,
      BCDU_WRITE = 3'b110
   } bcdu_phase_t;

   typedef struct packed
   {
      logic neg;
      logic ovf;
      logic zero;
      logic digit_carry_flag;
      logic carry;
   } bcdu_flags_t;
endpackage

/* File: rtl/bcdu_core.sv */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "bcdu_cfg.svh"
// How it works
// - Low nibble over 9 or digit carry: add 6
// - High nibble over 9 or carry: add 6, carry only
// - Decimal adjust is one fixed opcode word
// - Decrement file register to accumulator or register, flags
// - Bank bit clear: access bank, else bank pointer
module bcdu_core
   import bcdu_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o
);
   // ==========================================
   // State
   bcdu_phase_t phase;
   bcdu_flags_t flags;
   logic [15:0] instr;
   logic [7:0]  acc;
   logic [3:0]  bank_pointer_register;
   logic [7:0]  mem [0:2047];
   logic [10:0] op_addr;
   logic [7:0]  operand;
   logic [7:0]  result;
   logic        is_adj;
   logic        is_dec;
   logic        dest_file;
   bcdu_flags_t res_flags;

   // ==========================================
   // Bus decode
   logic setup;
   logic wr_acc;
   logic busy;
   logic mem_hit;
   assign setup   = psel_i && !penable_i;
   assign wr_acc  = psel_i && penable_i && pwrite_i && pready_o;
   assign busy    = (phase != BCDU_IDLE);
   assign mem_hit = (paddr_i[11] == 1'b1);

   // ==========================================
   // Decoder
   logic       next_is_adj;
   logic       next_is_dec;
   logic [7:0] fidx;
   logic [3:0] bank_sel;
   assign fidx        = instr[`BCDU_ADDR_MSB:0];
   assign next_is_adj = (instr == `BCDU_OP_ADJ_WORD);
   assign next_is_dec = ((instr & `BCDU_OP_DEC_MASK) == `BCDU_OP_DEC_MATCH);

   always_comb
   begin
      if (instr[`BCDU_BANK_BIT])
         bank_sel = bank_pointer_register;
      else if (fidx < `BCDU_ACC_SPLIT)
         bank_sel = 4'h0;
      else
         bank_sel = `BCDU_ACC_HI_BANK;
   end

   // ==========================================
   // Process
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic [4:0] hi_pre;
   logic       lo_fix;
   logic       hi_fix;
   logic [8:0] dec_full;
   logic [4:0] dec_lo;
   always_comb
   begin
      lo_fix = (operand[3:0] > `BCDU_BCD_MAX) || flags.digit_carry_flag;
      lo_sum = {1'b0, operand[3:0]} + (lo_fix ? {1'b0, `BCDU_BCD_FIX} : 5'h00);
      // High digit is judged after the low carry, so a sum like 9A still ends as BCD
      hi_pre = {1'b0, operand[7:4]} + {4'h0, lo_sum[4]};
      hi_fix = (hi_pre > {1'b0, `BCDU_BCD_MAX}) || flags.carry;
      hi_sum = hi_pre + (hi_fix ? {1'b0, `BCDU_BCD_FIX} : 5'h00);
      dec_full = {1'b0, operand} + {1'b0, ~`BCDU_DEC_STEP} + 9'h001;
      dec_lo   = {1'b0, operand[3:0]} + {1'b0, ~`BCDU_DEC_NIB} + 5'h01;
      res_flags = flags;
      if (is_adj)
      begin
         result          = {hi_sum[3:0], lo_sum[3:0]};
         res_flags.carry = hi_sum[4] | flags.carry;
      end
      else
      begin
         result                     = dec_full[7:0];
         res_flags.carry            = dec_full[8];
         res_flags.digit_carry_flag = dec_lo[4];
         res_flags.neg              = dec_full[7];
         res_flags.zero             = (dec_full[7:0] == 8'h00);
         res_flags.ovf              = (operand == `BCDU_DEC_OVF);
      end
   end

   // ==========================================
   // Phase sequencer: an instruction word write starts one instruction cycle
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         phase <= BCDU_IDLE;
      else
      begin
         unique case (phase)
            BCDU_IDLE:
               if (wr_acc && paddr_i == `BCDU_REG_INSTR)
                  phase <= BCDU_DECOD;
            BCDU_DECOD:
               phase <= (next_is_adj || next_is_dec) ? BCDU_READ : BCDU_IDLE;
            BCDU_READ:
               phase <= BCDU_PROC;
            BCDU_PROC:
               phase <= BCDU_WRITE;
            BCDU_WRITE:
               phase <= BCDU_IDLE;
            default:
               phase <= BCDU_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         is_adj    <= 1'b0;
         is_dec    <= 1'b0;
         dest_file <= 1'b0;
         op_addr   <= 11'h000;
      end
      else if (phase == BCDU_DECOD)
      begin
         is_adj    <= next_is_adj;
         is_dec    <= next_is_dec;
         dest_file <= instr[`BCDU_DEST_BIT];
         // Memory holds eight banks only, so bank bit 3 folds onto the lower eight
         op_addr   <= {bank_sel[2:0], fidx};
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         operand <= 8'h00;
      else if (phase == BCDU_READ)
         operand <= is_adj ? acc : mem[op_addr];
   end

   // ==========================================
   // Architectural state, bus writes only while idle
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         instr                 <= 16'h0000;
         acc                   <= 8'h00;
         flags                 <= '0;
         bank_pointer_register <= 4'h0;
      end
      else if (phase == BCDU_PROC)
      begin
         flags <= res_flags;
         if (is_adj || !dest_file)
            acc <= result;
      end
      else if (wr_acc && !busy)
      begin
         if (paddr_i == `BCDU_REG_INSTR)
            instr <= pwdata_i[15:0];
         if (paddr_i == `BCDU_REG_ACC)
            acc <= pwdata_i[7:0];
         if (paddr_i == `BCDU_REG_STATUS)
            flags <= pwdata_i[4:0];
         if (paddr_i == `BCDU_REG_BANK)
            bank_pointer_register <= pwdata_i[3:0];
      end
   end

   // Result for the file register lands in the write phase
   logic [7:0] wb_val;
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         wb_val <= 8'h00;
      else if (phase == BCDU_PROC)
         wb_val <= result;
   end

   always_ff @(posedge mclk_i)
   begin
      if (phase == BCDU_WRITE && is_dec && dest_file)
         mem[op_addr] <= wb_val;
      else if (wr_acc && !busy && mem_hit)
         mem[paddr_i[10:0]] <= pwdata_i[7:0];
   end

   // ==========================================
   // APB slave: pready registered in setup, so no wait states; errors on unmapped address
   logic       map_hit;
   logic [7:0] mem_rd;
   assign map_hit = mem_hit || paddr_i == `BCDU_REG_INSTR || paddr_i == `BCDU_REG_ACC
                 || paddr_i == `BCDU_REG_STATUS || paddr_i == `BCDU_REG_BANK;
   assign mem_rd  = mem[paddr_i[10:0]];

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else
      begin
         pready_o  <= setup;
         pslverr_o <= setup && !map_hit;
         if (!setup)
            prdata_o <= 32'h0000_0000;
         else if (mem_hit)
            prdata_o <= {24'h00_0000, mem_rd};
         else if (paddr_i == `BCDU_REG_INSTR)
            prdata_o <= {16'h0000, instr};
         else if (paddr_i == `BCDU_REG_ACC)
            prdata_o <= {24'h00_0000, acc};
         else if (paddr_i == `BCDU_REG_STATUS)
            prdata_o <= {23'h00_0000, busy, 3'h0, flags};
         else if (paddr_i == `BCDU_REG_BANK)
            prdata_o <= {28'h000_0000, bank_pointer_register};
         else
            prdata_o <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Checks
   sequence instr_cycle_s;
      phase == BCDU_READ ##1 phase == BCDU_PROC ##1 phase == BCDU_WRITE;
   endsequence

   phase_order_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_DECOD && (next_is_adj || next_is_dec) |=> instr_cycle_s ##1 phase == BCDU_IDLE)
      else $error("instruction cycle phases out of order");

   adj_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_adj && operand[3:0] <= `BCDU_BCD_MAX && !flags.digit_carry_flag
      |=> acc[3:0] == $past(operand[3:0]))
      else $error("low nibble changed without cause");

   adj_fix_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_adj && operand[3:0] > `BCDU_BCD_MAX
      |=> acc[3:0] == $past(operand[3:0]) + `BCDU_BCD_FIX)
      else $error("low nibble not corrected");

   adj_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_adj && operand[7:4] > `BCDU_BCD_MAX |=> flags.carry)
      else $error("carry not set after high correction");

   adj_flags_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_adj |=> flags[4:1] == $past(flags[4:1]))
      else $error("decimal adjust touched flags other than carry");

   dec_acc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_dec && !dest_file
      |=> acc == $past(operand) - 8'h01 && flags.zero == (acc == 8'h00))
      else $error("decrement to accumulator wrong");

   dec_file_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_PROC && is_dec && dest_file |=> ##1 mem[$past(op_addr, 2)] == $past(operand, 2) - 8'h01)
      else $error("decrement to register wrong");

   access_bank_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_DECOD && next_is_dec && !instr[`BCDU_BANK_BIT] && fidx < 8'h80
      |=> op_addr[10:8] == 3'h0)
      else $error("access bank not chosen");

   adj_decode_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      phase == BCDU_DECOD && instr == `BCDU_OP_ADJ_WORD |=> is_adj && !is_dec)
      else $error("decimal adjust opcode not decoded");
endmodule // bcdu_core

/* File: verification/bcdu_host.sv */
`timescale 1ns/1ps
module bcdu_host
(
   input  wire logic        mclk_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   input  wire logic [31:0] prdata_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [11:0] paddr_o,
   output logic      [31:0] pwdata_o
);
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'h000;
      pwdata_o = 32'h0000_0000;
   end
   // ==========================================
   // Bus cycle: enter just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge mclk_i);
      penable_o <= 1'b1;
      // Waits for pready however long; only the bench watchdog cuts a hang
      do
      begin
         @(posedge mclk_i);
      end
      while (pready_i !== 1'b1);
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Stale data is inverted so a late sample cannot look valid
      pwdata_o <= ~d;
      // One idle edge so no signal is driven twice in one step
      @(posedge mclk_i);
   endtask
endmodule // bcdu_host

/* File: verification/bcd_adjust_and_decrement_unit_tb.sv */
`timescale 1ns/1ps
`include "bcdu_cfg.svh"
module bcd_adjust_and_decrement_unit_tb;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   int          error_cnt = 0;
   int          num_checks = 0;
   always #20 mclk_i = ~mclk_i;
   bcdu_core bcdu_core_i (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   bcdu_host bcdu_host_i (.mclk_i(mclk_i), .pready_i(pready), .pslverr_i(pslverr),
      .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata));
   // ==========================================
   // Reference functions
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Low fix carries into the high nibble before it is judged
   function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic c, input logic dc);
      logic [8:0] t;
      t = {1'b0, a};
      if (a[3:0] > 4'h9 || dc)
         t = t + 9'h006;
      if (t[7:4] > 4'h9 || c || t[8])
         t = t + 9'h060;
      return {t[8] | c, t[7:0]};
   endfunction
   function automatic logic [4:0] dec_flags(input logic [7:0] v);
      logic [7:0] r;
      r = v - 8'h01;
      return {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
   endfunction
   // ==========================================
   // Bus helpers and checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      bcdu_host_i.xfer(w, a, d, rd, er);
   endtask
   // Leaves the final status word in rd; j adds a write while busy
   task automatic run(input logic [15:0] op, input logic j);
      int   n;
      logic known;
      n = 0;
      acc(1'b1, `BCDU_REG_INSTR, {16'h0000, op});
      if (j)
         acc(1'b1, `BCDU_REG_ACC, 32'h0000_00FF);
      do
      begin
         acc(1'b0, `BCDU_REG_STATUS, 32'h0000_0000);
         n++;
      end
      while (rd[`BCDU_ST_BUSY] !== 1'b0 && n < 20);
      chk({31'h0, rd[`BCDU_ST_BUSY]}, 32'h0000_0000);
      // Four phases follow a known opcode, so the first poll still sees busy
      known = op == `BCDU_OP_ADJ_WORD || (op & `BCDU_OP_DEC_MASK) == `BCDU_OP_DEC_MATCH;
      chk(n, (known && !j) ? 32'h0000_0002 : 32'h0000_0001);
   endtask
   task automatic results;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      logic [7:0]  a, v, r, f;
      logic [4:0]  st;
      logic [8:0]  t;
      logic [3:0]  eb;
      logic [11:0] m;
      seed = 32'h0001_0E3C;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      acc(1'b0, `BCDU_REG_ACC, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b0, 12'h010, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      for (int i = 0; i < 14; i++)
      begin
         seed = lfsr(seed);
         a = (i == 0) ? 8'hA5 : (i == 1) ? 8'hCE : (i == 2) ? 8'h19 : seed[7:0];
         st = (i < 2) ? 5'h00 : (i == 2) ? 5'h02 : seed[12:8];
         acc(1'b1, `BCDU_REG_STATUS, {27'h0, st});
         acc(1'b1, `BCDU_REG_ACC, {24'h0, a});
         run(`BCDU_OP_ADJ_WORD, i == 0);
         t = bcd_fix(a, st[0], st[1]);
         chk({27'h0, rd[4:0]}, {27'h0, st[4:1], t[8]});
         acc(1'b0, `BCDU_REG_ACC, 32'h0000_0000);
         chk(rd, {24'h0, t[7:0]});
      end
      run(16'h0107, 1'b0);
      acc(1'b0, `BCDU_REG_ACC, 32'h0000_0000);
      chk(rd, {24'h0, t[7:0]});
      for (int i = 0; i < 16; i++)
      begin
         seed = lfsr(seed);
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'h10 : seed[7:0];
         f = {seed[17:12], 2'b00};
         eb = seed[9] ? seed[21:18] : {4{f[7]}};
         m = 12'h800 | {1'b0, eb[2:0], f};
         r = v - 8'h01;
         acc(1'b1, `BCDU_REG_BANK, {28'h0, seed[21:18]});
         acc(1'b1, `BCDU_REG_ACC, {24'h0, seed[31:24]});
         acc(1'b1, m, {24'h0, v});
         run({6'h01, seed[8], seed[9], f}, 1'b0);
         chk({27'h0, rd[4:0]}, {27'h0, dec_flags(v)});
         acc(1'b0, `BCDU_REG_ACC, 32'h0000_0000);
         chk(rd, {24'h0, seed[8] ? seed[31:24] : r});
         acc(1'b0, m, 32'h0000_0000);
         chk(rd, {24'h0, seed[8] ? r : v});
      end
      results;
   end
   // About 660 cycles expected; over twenty times that cuts a hang
   initial
   begin
      #600_000;
      error_cnt++;
      results;
   end
endmodule // bcd_adjust_and_decrement_unit_tb
